// >>> design/pm_pkg.sv
`default_nettype none
package pm_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int unsigned NUM_PADS = 35;            // Pad positions 0..34
  localparam int unsigned CODE_W   = 6;             // Function code width
  localparam int unsigned NUM_FN   = 41;            // Function codes 0..40
  localparam logic [5:0]  FN_LAST  = 6'h28;         // Highest valid code
  localparam int unsigned NUM_ANA  = 10;            // Analog lines
  localparam int unsigned NUM_KSI  = 16;            // Key scan rows in
  localparam int unsigned NUM_KSO  = 18;            // Key scan columns out

  // ************************************************************
  // Fixed pad positions
  // ************************************************************
  localparam int unsigned TEST_PIN_PAD = 8;         // Test-mode pin, never muxed
  localparam int unsigned JT_TDO   = 0;             // Debug data out
  localparam int unsigned JT_TDI   = 1;             // Debug data in
  localparam int unsigned JT_TMS   = 2;             // Debug mode select
  localparam int unsigned JT_TCK   = 3;             // Debug clock

  // Pad carrying each analog line, line 0 first
  localparam int unsigned ANA_PAD [NUM_ANA] = '{11, 12, 13, 14, 15, 16, 17, 18, 19, 20};

  // ************************************************************
  // Function code attributes, bit n belongs to code n
  // ************************************************************
  localparam logic [40:0] FN_DRIVES = 41'h03A_0077_FD7F;  // Output or two-way
  localparam logic [40:0] FN_SENSES = 41'h1C5_FFBB_02BF;  // Input or two-way
  localparam logic [40:0] FN_IDLE   = 41'h000_0033_023F;  // Level when unrouted

  // ************************************************************
  // Key scan pad table: {used, is_out, index[4:0]}
  // ************************************************************
  localparam logic [6:0] KS_MAP [NUM_PADS] = '{
    7'h40, 7'h60, 7'h41, 7'h61, 7'h69, 7'h4A, 7'h6A, 7'h4B, 7'h00, 7'h64,
    7'h44, 7'h6B, 7'h4C, 7'h6C, 7'h62, 7'h42, 7'h70, 7'h71, 7'h45, 7'h4D,
    7'h65, 7'h6D, 7'h4E, 7'h46, 7'h63, 7'h43, 7'h6E, 7'h49, 7'h68, 7'h4F,
    7'h6F, 7'h67, 7'h47, 7'h66, 7'h48};

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [34:0] PAD_RST  = 35'h0_0000_0000;  // Pads released
  localparam logic [40:0] FN_RST   = FN_IDLE;          // Inputs idle
  localparam logic [15:0] KSI_RST  = 16'hFFFF;         // Rows idle high
  localparam logic        TCK_IDLE = 1'b0;             // Debug clock idle
  localparam logic        TMS_IDLE = 1'b1;             // Debug select idle
  localparam logic        TDI_IDLE = 1'b1;             // Debug data idle

  // ************************************************************
  // Types
  // ************************************************************
  typedef logic [CODE_W-1:0] pm_code_t;

  typedef struct packed {
    logic [40:0] out;     // Value per function code
    logic [40:0] oe;      // Drive request for two-way codes
  } pm_fn_s;

  typedef struct packed {
    logic [34:0] out;     // Pad output level
    logic [34:0] oe;      // Pad output enable
    logic [34:0] ana;     // Pad tied to internal analog line
  } pm_pad_s;

endpackage
`default_nettype wire

// >>> design/pm_pad_mux.sv
`timescale 1ns/1ps
`default_nettype none
module pm_pad_mux (
  input  wire logic                          clk_i,          // System clock
  input  wire logic                          resetn_i,       // Sync reset, low
  input  wire logic [34:0]                   pad_in_i,       // Pad levels
  output var  pm_pkg::pm_pad_s               pad_o,          // Pad drive
  input  wire logic [34:0]                   fn_en_i,        // Full-mux enable
  input  wire pm_pkg::pm_code_t [34:0]       function_code_i,// Code per pad
  input  wire pm_pkg::pm_fn_s                fn_drv_i,       // Peripheral drive
  output var  logic [40:0]                   fn_in_o,        // Peripheral inputs
  input  wire logic                          jtag_off_i,     // High parks debug
  input  wire logic                          jtag_tdo_i,     // Debug data out
  input  wire logic                          jtag_tdo_oe_i,  // Debug out enable
  output var  logic                          jtag_tdi_o,     // Debug data in
  output var  logic                          jtag_tms_o,     // Debug mode sel
  output var  logic                          jtag_tck_o,     // Debug clock
  input  wire logic [9:0]                    analog_en_i,    // Analog line en
  input  wire logic [34:0]                   gpio_en_i,      // GPIO claim
  input  wire logic [34:0]                   gpio_out_i,     // GPIO level
  input  wire logic [34:0]                   gpio_oe_i,      // GPIO enable
  output var  logic [34:0]                   gpio_in_o,      // GPIO samples
  input  wire logic [15:0]                   ks_in_en_i,     // Key row enable
  input  wire logic [17:0]                   ks_out_en_i,    // Key col enable
  input  wire logic [17:0]                   ks_out_i,       // Key col level
  output var  logic [15:0]                   ks_in_o,        // Key row samples
  output var  logic                          test_mode_o     // Test-mode pin
);

  // ************************************************************
  // Pad input synchroniser
  // ************************************************************
  logic [34:0] pad_meta_ff;     // First stage, read only by second
  logic [34:0] pad_sync_ff;     // Safe copy of pad levels

  // Two flops: pads are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pad_meta_ff <= pm_pkg::PAD_RST;
      pad_sync_ff <= pm_pkg::PAD_RST;
    end else begin
      pad_meta_ff <= pad_in_i;
      pad_sync_ff <= pad_meta_ff;
    end
  end

  // ************************************************************
  // Fixed-pad claims
  // ************************************************************
  wire         jtag_on = !jtag_off_i;   // Low port at reset keeps debug live
  logic [34:0] jt_claim;                // Debug owns pad
  logic [34:0] ana_claim;               // Analog owns pad
  logic [34:0] ks_claim;                // Key scan owns pad
  logic [34:0] gp_claim;                // GPIO owns pad
  logic [34:0] mux_ok;                  // Full-mux selection applies

  // Analog lines onto their pads
  always_comb begin
    ana_claim = '0;
    for (int l = 0; l < pm_pkg::NUM_ANA; l++) begin
      ana_claim[pm_pkg::ANA_PAD[l]] = analog_en_i[l];
    end
  end

  // ************************************************************
  // Per-pad output selection
  // ************************************************************
  logic [34:0] nxt_out;       // Pad level next
  logic [34:0] nxt_oe;        // Pad enable next

  genvar p;
  generate
    for (p = 0; p < pm_pkg::NUM_PADS; p++) begin : g_pad
      localparam logic [6:0] KS          = pm_pkg::KS_MAP[p];
      localparam logic       IS_TEST_PIN = (p == pm_pkg::TEST_PIN_PAD);
      wire pm_pkg::pm_code_t code = function_code_i[p];
      wire pm_pkg::pm_code_t cidx;    // Code guarded against out of range

      assign jt_claim[p] = jtag_on && (p <= pm_pkg::JT_TCK);
      assign ks_claim[p] = KS[6] && (KS[5] ? ks_out_en_i[KS[4:0]] : ks_in_en_i[KS[3:0]]);
      assign gp_claim[p] = gpio_en_i[p];
      // Enable gates the code; test pad never muxed; specials win
      assign mux_ok[p]   = fn_en_i[p] && !IS_TEST_PIN && (code <= pm_pkg::FN_LAST)
                         && !(jt_claim[p] || ana_claim[p] || ks_claim[p] || gp_claim[p]);
      assign cidx        = mux_ok[p] ? code : '0;

      // Priority: debug, analog, key scan, GPIO, full mux
      always_comb begin
        nxt_out[p] = 1'b0;
        nxt_oe[p]  = 1'b0;
        if (IS_TEST_PIN) begin
          // Test pin is input only
          nxt_oe[p] = 1'b0;
        end else if (jt_claim[p]) begin
          // Only pad 0 drives, others feed the debug port
          nxt_out[p] = (p == pm_pkg::JT_TDO) ? jtag_tdo_i : 1'b0;
          nxt_oe[p]  = (p == pm_pkg::JT_TDO) ? jtag_tdo_oe_i : 1'b0;
        end else if (ana_claim[p]) begin
          // Digital drive parked while analog line is attached
          nxt_oe[p] = 1'b0;
        end else if (ks_claim[p]) begin
          // Columns drive, rows listen
          nxt_out[p] = KS[5] ? ks_out_i[KS[4:0]] : 1'b0;
          nxt_oe[p]  = KS[5];
        end else if (gp_claim[p]) begin
          nxt_out[p] = gpio_out_i[p];
          nxt_oe[p]  = gpio_oe_i[p];
        end else if (mux_ok[p]) begin
          // Output codes always drive; two-way codes follow the peripheral
          nxt_out[p] = fn_drv_i.out[cidx];
          nxt_oe[p]  = pm_pkg::FN_DRIVES[cidx]
                     && (!pm_pkg::FN_SENSES[cidx] || fn_drv_i.oe[cidx]);
        end else begin
          // Unclaimed pad stays released
          nxt_oe[p] = 1'b0;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Per-function input routing
  // ************************************************************
  logic [40:0] nxt_fn_in;     // Peripheral input levels next

  genvar c;
  genvar q;
  generate
    for (c = 0; c < pm_pkg::NUM_FN; c++) begin : g_fn
      wire [34:0] hit;        // Pads selecting this code when it is an input
      for (q = 0; q < pm_pkg::NUM_PADS; q++) begin : g_hit
        assign hit[q] = mux_ok[q] && (function_code_i[q] == pm_pkg::pm_code_t'(c))
                      && pm_pkg::FN_SENSES[c];
      end
      // Several pads on one input are ORed; none gives the idle level
      assign nxt_fn_in[c] = (|hit) ? |(hit & pad_sync_ff) : pm_pkg::FN_IDLE[c];
    end
  endgenerate

  // ************************************************************
  // Key scan rows
  // ************************************************************
  logic [15:0] nxt_ks_in;     // Row levels next

  // Rows default high; a claimed row pad overrides
  always_comb begin
    nxt_ks_in = pm_pkg::KSI_RST;
    for (int k = 0; k < pm_pkg::NUM_PADS; k++) begin
      if (pm_pkg::KS_MAP[k][6] && !pm_pkg::KS_MAP[k][5] && ks_claim[k]
          && !jt_claim[k] && !ana_claim[k]) begin
        nxt_ks_in[pm_pkg::KS_MAP[k][3:0]] = pad_sync_ff[k];
      end
    end
  end

  // ************************************************************
  // Debug inputs
  // ************************************************************
  wire nxt_tdi = jtag_on ? pad_sync_ff[pm_pkg::JT_TDI] : pm_pkg::TDI_IDLE;
  wire nxt_tms = jtag_on ? pad_sync_ff[pm_pkg::JT_TMS] : pm_pkg::TMS_IDLE;
  wire nxt_tck = jtag_on ? pad_sync_ff[pm_pkg::JT_TCK] : pm_pkg::TCK_IDLE;

  // ************************************************************
  // Output registers
  // ************************************************************
  // Pad side; trades one cycle of latency for glitch-free enables
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pad_o.out <= pm_pkg::PAD_RST;
      pad_o.oe  <= pm_pkg::PAD_RST;
      pad_o.ana <= pm_pkg::PAD_RST;
    end else begin
      pad_o.out <= nxt_out;
      pad_o.oe  <= nxt_oe;
      pad_o.ana <= ana_claim;
    end
  end

  // Peripheral side
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fn_in_o     <= pm_pkg::FN_RST;
      gpio_in_o   <= pm_pkg::PAD_RST;
      ks_in_o     <= pm_pkg::KSI_RST;
      test_mode_o <= 1'b0;
    end else begin
      fn_in_o     <= nxt_fn_in;
      gpio_in_o   <= pad_sync_ff;
      ks_in_o     <= nxt_ks_in;
      test_mode_o <= pad_sync_ff[pm_pkg::TEST_PIN_PAD];
    end
  end

  // Debug port; idle levels while parked
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      jtag_tdi_o <= pm_pkg::TDI_IDLE;
      jtag_tms_o <= pm_pkg::TMS_IDLE;
      jtag_tck_o <= pm_pkg::TCK_IDLE;
    end else begin
      jtag_tdi_o <= nxt_tdi;
      jtag_tms_o <= nxt_tms;
      jtag_tck_o <= nxt_tck;
    end
  end

endmodule
`default_nettype wire

// >>> test/pm_pad_world.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Pad wires seen from outside the die
// ************************************************************
module pm_pad_world (
  input  wire logic            clk_i,      // System clock
  input  wire pm_pkg::pm_pad_s pad_drv_i,  // Drive from the mux
  input  wire logic [34:0]     ext_en_i,   // Board drives these pads
  input  wire logic [34:0]     ext_lvl_i,  // Board level per pad
  output var  logic [34:0]     pad_lvl_o   // Resolved wire level
);
  logic [34:0] float_ff = '0;  // Level of a pad nobody drives
  // Floating pads toggle, so a stale sample never looks valid
  always @(posedge clk_i) begin
    float_ff <= ~float_ff;
  end
  // Mux drive wins, then board drive, else the floating pattern
  assign pad_lvl_o = (pad_drv_i.oe & pad_drv_i.out) | (~pad_drv_i.oe & ext_en_i & ext_lvl_i)
                   | (~pad_drv_i.oe & ~ext_en_i & float_ff);
endmodule
`default_nettype wire

// >>> test/pm_pad_mux_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Port checker for the pad mux
// ************************************************************
module pm_pad_mux_assertions (
  input wire logic                    clk_i,
  input wire logic                    resetn_i,
  input wire logic [34:0]             pad_in_i,
  input wire pm_pkg::pm_pad_s         pad_o,
  input wire logic [34:0]             fn_en_i,
  input wire pm_pkg::pm_code_t [34:0] function_code_i,
  input wire pm_pkg::pm_fn_s          fn_drv_i,
  input wire logic [40:0]             fn_in_o,
  input wire logic                    jtag_off_i,
  input wire logic                    jtag_tdo_i,
  input wire logic                    jtag_tdo_oe_i,
  input wire logic                    jtag_tck_o,
  input wire logic [9:0]              analog_en_i,
  input wire logic [34:0]             gpio_en_i,
  input wire logic [15:0]             ks_in_en_i,
  input wire logic [17:0]             ks_out_en_i
);
  // No analog, GPIO or key scan function claims any pad
  wire quiet = ~|{analog_en_i, gpio_en_i, ks_in_en_i, ks_out_en_i};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Receive code held on pad 14 alone
  sequence rx_on_p14;
    quiet && fn_en_i == 35'h0_0000_4000 && function_code_i[14] == 6'h09;
  endsequence
  // Debug port left live
  sequence debug_live;
    !jtag_off_i;
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) !resetn_i |=> pad_o == '0 && fn_in_o == pm_pkg::FN_IDLE)
    else $error("outputs not idle in reset");
  pad_eight_a: assert property (!pad_o.oe[8])
    else $error("pad 8 driven");
  uart_out_a: assert property (quiet && fn_en_i[13] && function_code_i[13] == 6'h08
    |=> pad_o.oe[13] && pad_o.out[13] == $past(fn_drv_i.out[8])) else $error("transmit not on pad");
  rx_path_a: assert property (rx_on_p14 [*3] |=> fn_in_o[9] == $past(pad_in_i[14], 3))
    else $error("receive input not from pad");
  gate_off_a: assert property (quiet && !fn_en_i[9] |=> !pad_o.oe[9])
    else $error("disabled pad drives");
  debug_out_a: assert property (!jtag_off_i |=> pad_o.out[0] == $past(jtag_tdo_i)
    && pad_o.oe[0] == $past(jtag_tdo_oe_i)) else $error("debug data out wrong");
  debug_clk_a: assert property (debug_live [*3] |=> jtag_tck_o == $past(pad_in_i[3], 3)
    && !pad_o.oe[3]) else $error("debug clock wrong");
  analog_claim_a: assert property (analog_en_i[0] |=> pad_o.ana[11] && !pad_o.oe[11])
    else $error("analog pad not claimed");
  idle_input_a: assert property (fn_en_i == '0 |=> fn_in_o == pm_pkg::FN_IDLE)
    else $error("unrouted input not idle");
endmodule
bind pm_pad_mux pm_pad_mux_assertions u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .pad_in_i(pad_in_i),
  .pad_o(pad_o), .fn_en_i(fn_en_i), .function_code_i(function_code_i), .fn_drv_i(fn_drv_i),
  .fn_in_o(fn_in_o), .jtag_off_i(jtag_off_i), .jtag_tdo_i(jtag_tdo_i), .jtag_tdo_oe_i(jtag_tdo_oe_i),
  .jtag_tck_o(jtag_tck_o), .analog_en_i(analog_en_i), .gpio_en_i(gpio_en_i), .ks_in_en_i(ks_in_en_i),
  .ks_out_en_i(ks_out_en_i));
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ************************************************************
  // Bench signals
  // ************************************************************
  localparam logic [40:0] drv_m   = 41'h03A_0077_FD7F;  // Codes that may drive
  localparam logic [40:0] bidir_m = 41'h000_0033_003F;  // Two-way codes
  logic                    clk_i, resetn_i, jtag_off, tdo, tdo_oe, tdi, tms, tck, test_pin;
  logic [34:0]             pad_in, fn_en, g_en, g_out, g_oe, g_in, ext_en, ext_lvl;
  logic [40:0]             fn_in, exp_v;
  logic [17:0]             ks_oe, ks_o;
  logic [15:0]             ks_ie, ks_in;
  logic [9:0]              ana_en;
  pm_pkg::pm_code_t [34:0] fcode;
  pm_pkg::pm_fn_s          fn_drv;
  pm_pkg::pm_pad_s         pad_o;
  int                      num_errors = 0, cmp_count = 0, p;
  pm_pad_mux u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .pad_in_i(pad_in), .pad_o(pad_o),
    .fn_en_i(fn_en), .function_code_i(fcode), .fn_drv_i(fn_drv), .fn_in_o(fn_in),
    .jtag_off_i(jtag_off), .jtag_tdo_i(tdo), .jtag_tdo_oe_i(tdo_oe), .jtag_tdi_o(tdi),
    .jtag_tms_o(tms), .jtag_tck_o(tck), .analog_en_i(ana_en), .gpio_en_i(g_en),
    .gpio_out_i(g_out), .gpio_oe_i(g_oe), .gpio_in_o(g_in), .ks_in_en_i(ks_ie),
    .ks_out_en_i(ks_oe), .ks_out_i(ks_o), .ks_in_o(ks_in), .test_mode_o(test_pin));
  pm_pad_world u_world (.clk_i(clk_i), .pad_drv_i(pad_o), .ext_en_i(ext_en), .ext_lvl_i(ext_lvl),
    .pad_lvl_o(pad_in));
  // ************************************************************
  // Tasks
  // ************************************************************
  // Inputs move on falling edges only
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    conclude();
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {resetn_i, jtag_off, fn_en, fcode, fn_drv, ana_en, g_en, g_out, g_oe, ks_ie, ks_oe, ks_o} = '0;
    tdo = 1'b1;
    tdo_oe = 1'b1;
    ext_en = 35'hE;  // Debug clock high, data and select low
    ext_lvl = 35'h8;
    step(8);
    chk(41'(pad_o.oe | pad_o.out | pad_o.ana), 41'h0);
    chk(fn_in, pm_pkg::FN_IDLE);
    chk(41'({tdi, tms, tck, ks_in}), 41'h6_FFFF);
    resetn_i = 1'b1;
    step(5);
    chk(41'({pad_o.oe[0], pad_o.out[0], tdi, tms, tck}), 41'h19);
    $display("reset and debug test done");
    // Every code on a spread of pads: drive, two-way release, input path
    jtag_off = 1'b1;
    for (int c = 0; c <= 40; c++) begin
      p = c % 30 + 4;
      if (p >= 8) p++;
      fn_en = '0;
      fn_en[p] = 1'b1;
      fcode[p] = 6'(c);
      ext_en = '0;
      fn_drv.oe = '1;
      fn_drv.out = 41'h1 << c;
      step(2);
      chk(41'({pad_o.oe[p], pad_o.out[p] & pad_o.oe[p]}), 41'({drv_m[c], drv_m[c]}));
      fn_drv.oe = '0;
      fn_drv.out = ~(41'h1 << c);
      step(2);
      chk(41'({pad_o.oe[p], pad_o.out[p] & pad_o.oe[p]}), 41'({drv_m[c] & ~bidir_m[c], 1'b0}));
      ext_en[p] = 1'b1;
      ext_lvl[p] = ~pm_pkg::FN_IDLE[c];
      exp_v = pm_pkg::FN_IDLE;
      if (!(drv_m[c] && !bidir_m[c])) exp_v[c] = ~pm_pkg::FN_IDLE[c];
      step(4);
      chk(fn_in, exp_v);
    end
    $display("full mux code test done");
    // Pad 8 enabled by mistake stays released; its level reaches test mode
    fn_en = 35'h100;
    fcode[8] = 6'h08;
    fn_drv = '1;
    ext_en = 35'h100;
    ext_lvl = 35'h100;
    step(4);
    chk(41'(pad_o.oe[8]), 41'h0);
    chk(41'(test_pin), 41'h1);
    chk(41'(g_in[8]), 41'h1);
    $display("test mode pad test done");
    // Fixed functions over a full mux on every pad but 5 and 8
    fn_en = 35'h7_FFFF_FEDF;
    fcode = {35{6'h08}};
    ana_en = '1;
    jtag_off = 1'b0;
    tdo = 1'b0;
    tdo_oe = 1'b0;
    {g_en[6], g_oe[6], g_out[6]} = 3'b110;
    ks_oe[9] = 1'b1;
    ks_ie[10] = 1'b1;
    ext_en = 35'h20;
    ext_lvl = '0;
    step(4);
    chk(41'(pad_o.ana), 41'h1F_F800);
    chk(41'(pad_o.oe & 35'h1F_F800), 41'h0);
    chk(41'({pad_o.out[0], pad_o.oe[0], pad_o.out[4], pad_o.out[6], pad_o.oe[6]}), 41'h1);
    chk(41'(g_in[6:5]), 41'h0);
    chk(41'(ks_in), 41'hFBFF);
    jtag_off = 1'b1;
    step(2);
    chk(41'({tdi, tms, tck}), 41'h6);
    $display("fixed function test done");
    conclude();
  end
endmodule
`default_nettype wire
